// *** src/dcb_pkg.sv ***
// constants, field layouts and state types of the converter code bank
// assumes a byte-wide register port with an 8-bit register address
package dcb_pkg;

  localparam int CODE_W = 14;
  localparam int CHAN_N = 6;
  localparam int LO_W = 6;
  localparam int LO_LSB = 2;
  localparam int SEL_W = 6;

  // register offsets
  localparam logic [7:0] OFS_CH3_LO = 8'h2c;
  localparam logic [7:0] OFS_CH3_HI = 8'h2d;
  localparam logic [7:0] OFS_CH4_LO = 8'h2e;
  localparam logic [7:0] OFS_CH4_HI = 8'h2f;
  localparam logic [7:0] OFS_CH5_LO = 8'h30;
  localparam logic [7:0] OFS_CH5_HI = 8'h31;
  localparam logic [7:0] OFS_BC_LO = 8'h32;
  localparam logic [7:0] OFS_BC_HI = 8'h33;
  localparam logic [7:0] OFS_SEL = 8'h34;
  localparam logic [7:0] OFS_BI_LO = 8'h35;
  localparam logic [7:0] OFS_BI_HI = 8'h36;
  localparam logic [7:0] OFS_SW_LOAD = 8'h37;
  localparam logic [7:0] OFS_CH0_IN_LO = 8'h38;
  localparam logic [7:0] OFS_CH0_IN_HI = 8'h39;

  // channel numbers behind the directly mapped code registers
  localparam logic [2:0] CH3_IDX = 3'h3;
  localparam logic [2:0] CH4_IDX = 3'h4;
  localparam logic [2:0] CH5_IDX = 3'h5;

  // values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [13:0] RESET_CODE = 14'h0000;
  localparam logic [5:0] RESET_SEL = 6'h00;
  localparam logic [1:0] RSVD_LO = 2'h0;
  localparam logic [1:0] RSVD_SEL = 2'h0;

  // bank state: broadcast codes, select and read answer
  typedef struct packed {
    logic [CODE_W-1:0] bc_code;
    logic [CODE_W-1:0] bi_code;
    logic [SEL_W-1:0] sel;
    logic [7:0] rdata;
    logic rvalid;
    logic err;
  } dcb_bank_s;

  // per-channel state: converter and input code
  typedef struct packed {
    logic [CODE_W-1:0] conv;
    logic [CODE_W-1:0] in_code;
  } dcb_chan_s;

endpackage : dcb_pkg

// *** src/dcb_chan_if.sv ***
// update requests from the bank to the channel units, codes back
// assumes one driver per element: the bank drives requests, unit i
// drives element i of the code arrays
`timescale 1ns/100ps
interface dcb_chan_if;
  logic [dcb_pkg::CHAN_N-1:0] conv_we;
  logic [dcb_pkg::CHAN_N-1:0] in_we;
  logic [dcb_pkg::CHAN_N-1:0] load;
  logic [dcb_pkg::CODE_W-1:0] conv_val [dcb_pkg::CHAN_N];
  logic [dcb_pkg::CODE_W-1:0] in_val [dcb_pkg::CHAN_N];
  logic [dcb_pkg::CODE_W-1:0] conv_code [dcb_pkg::CHAN_N];
  logic [dcb_pkg::CODE_W-1:0] in_code [dcb_pkg::CHAN_N];

  modport ctrl (
    output conv_we, in_we, load, conv_val, in_val,
    input conv_code, in_code
  );
  modport unit (
    input conv_we, in_we, load, conv_val, in_val,
    output conv_code, in_code
  );
endinterface : dcb_chan_if

// *** src/dcb_chan_unit.sv ***
// one channel: input code register and converter code register
// assumes requests from the bank are one-cycle and mutually consistent
`timescale 1ns/100ps
module dcb_chan_unit #(
  parameter int IDX = 0
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  dcb_chan_if.unit bus
);

  dcb_pkg::dcb_chan_s state_reg;
  dcb_pkg::dcb_chan_s state_next;

  // direct or broadcast write beats a software load in the same cycle
  always_comb begin
    state_next = state_reg;
    if (bus.conv_we[IDX]) begin
      state_next.conv = bus.conv_val[IDX]; // see RL6
    end else if (bus.load[IDX]) begin
      // the load moves the input value held before this edge
      state_next.conv = state_reg.in_code; // see RL12
    end
    if (bus.in_we[IDX]) begin
      state_next.in_code = bus.in_val[IDX]; // see RL7
    end
  end

  // synchronous reset clears both codes
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_reg.conv <= dcb_pkg::RESET_CODE; // see RL4
      state_reg.in_code <= dcb_pkg::RESET_CODE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.conv_code[IDX] = state_reg.conv;
  assign bus.in_code[IDX] = state_reg.in_code;

endmodule : dcb_chan_unit

// *** src/dcb_code_bank.sv ***
// converter code register bank with broadcast and software load
// assumes the serial host port is already deserialised into one
// byte-wide access per cycle, synchronous to clk_sys_in
//
// What this block does
// RL1: low byte bits 7:2 hold code 5:0
// RL2: high byte holds code 13:6, read/write
// RL3: low byte bits 1:0 read zero
// RL4: all registers reset to zero
// RL5: channel 3 to 5 code map fixed
// RL6: broadcast code copied to selected converter
// RL7: broadcast input copied to selected inputs
// RL8: broadcast code at 0x32 and 0x33
// RL9: broadcast input at 0x35 and 0x36
// RL10: select bit n picks channel n
// RL11: write-only load trigger at 0x37
// RL12: trigger bit n loads channel n, self-clears
// RL13: channel 0 input at 0x38 and 0x39
// RL14: copy on either half, current select
`timescale 1ns/100ps
module dcb_code_bank (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic reg_err_out,
  output logic [dcb_pkg::CHAN_N-1:0][dcb_pkg::CODE_W-1:0] conv_codes_out,
  output logic [dcb_pkg::CHAN_N-1:0][dcb_pkg::CODE_W-1:0] input_codes_out
);

  dcb_pkg::dcb_bank_s bank_reg;
  dcb_pkg::dcb_bank_s bank_next;

  dcb_chan_if chan_bus ();

  // decoded write target
  logic dir_hit;
  logic dir_hi;
  logic [2:0] dir_ch;
  logic wr_bc;
  logic wr_bi;
  logic wr_load;
  logic wr_in0;
  logic wr_in0_hi;
  logic wr_mapped;
  logic rd_mapped;
  logic [7:0] rd_byte;
  logic [dcb_pkg::CODE_W-1:0] bc_new;
  logic [dcb_pkg::CODE_W-1:0] bi_new;

  // one unit per channel; the bank only steers them
  for (genvar g = 0; g < dcb_pkg::CHAN_N; g++) begin : g_chan
    dcb_chan_unit #(
      .IDX(g)
    ) u_chan (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .bus(chan_bus)
    );
    assign conv_codes_out[g] = chan_bus.conv_code[g];
    assign input_codes_out[g] = chan_bus.in_code[g];
  end

  // write address decode
  always_comb begin
    dir_hit = 1'b0;
    dir_hi = 1'b0;
    dir_ch = 3'h0;
    wr_bc = 1'b0;
    wr_bi = 1'b0;
    wr_load = 1'b0;
    wr_in0 = 1'b0;
    wr_in0_hi = 1'b0;
    wr_mapped = 1'b1;
    case (reg_addr_in)
      dcb_pkg::OFS_CH3_LO: begin
        dir_hit = 1'b1;
        dir_ch = dcb_pkg::CH3_IDX;
      end
      dcb_pkg::OFS_CH3_HI: begin
        dir_hit = 1'b1; // see RL5
        dir_hi = 1'b1;
        dir_ch = dcb_pkg::CH3_IDX;
      end
      dcb_pkg::OFS_CH4_LO: begin
        dir_hit = 1'b1; // see RL5
        dir_ch = dcb_pkg::CH4_IDX;
      end
      dcb_pkg::OFS_CH4_HI: begin
        dir_hit = 1'b1;
        dir_hi = 1'b1;
        dir_ch = dcb_pkg::CH4_IDX;
      end
      dcb_pkg::OFS_CH5_LO: begin
        dir_hit = 1'b1; // see RL5
        dir_ch = dcb_pkg::CH5_IDX;
      end
      dcb_pkg::OFS_CH5_HI: begin
        dir_hit = 1'b1;
        dir_hi = 1'b1;
        dir_ch = dcb_pkg::CH5_IDX;
      end
      dcb_pkg::OFS_BC_LO: wr_bc = 1'b1;
      dcb_pkg::OFS_BC_HI: wr_bc = 1'b1;
      dcb_pkg::OFS_SEL: wr_mapped = 1'b1;
      dcb_pkg::OFS_BI_LO: wr_bi = 1'b1;
      dcb_pkg::OFS_BI_HI: wr_bi = 1'b1;
      dcb_pkg::OFS_SW_LOAD: wr_load = 1'b1; // see RL11
      dcb_pkg::OFS_CH0_IN_LO: wr_in0 = 1'b1;
      dcb_pkg::OFS_CH0_IN_HI: begin
        wr_in0 = 1'b1; // see RL13
        wr_in0_hi = 1'b1;
      end
      default: wr_mapped = 1'b0;
    endcase
  end

  // broadcast codes as they stand after this write, both halves merged
  always_comb begin
    bc_new = bank_reg.bc_code;
    bi_new = bank_reg.bi_code;
    if (reg_wr_in && reg_addr_in == dcb_pkg::OFS_BC_LO) begin
      bc_new[dcb_pkg::LO_W-1:0] = reg_wdata_in[7:dcb_pkg::LO_LSB]; // see RL8
    end
    if (reg_wr_in && reg_addr_in == dcb_pkg::OFS_BC_HI) begin
      bc_new[dcb_pkg::CODE_W-1:dcb_pkg::LO_W] = reg_wdata_in; // see RL8
    end
    if (reg_wr_in && reg_addr_in == dcb_pkg::OFS_BI_LO) begin
      bi_new[dcb_pkg::LO_W-1:0] = reg_wdata_in[7:dcb_pkg::LO_LSB]; // see RL9
    end
    if (reg_wr_in && reg_addr_in == dcb_pkg::OFS_BI_HI) begin
      bi_new[dcb_pkg::CODE_W-1:dcb_pkg::LO_W] = reg_wdata_in; // see RL9
    end
  end

  // per-channel requests; only one register is written per cycle,
  // so direct, broadcast and load requests never meet on one channel
  always_comb begin
    logic [dcb_pkg::CODE_W-1:0] cur;
    cur = dcb_pkg::RESET_CODE;
    for (int i = 0; i < dcb_pkg::CHAN_N; i++) begin
      chan_bus.conv_we[i] = 1'b0;
      chan_bus.in_we[i] = 1'b0;
      chan_bus.load[i] = 1'b0;
      chan_bus.conv_val[i] = bc_new;
      chan_bus.in_val[i] = bi_new;
      cur = chan_bus.conv_code[i];
      if (reg_wr_in && dir_hit && dir_ch == 3'(i)) begin
        chan_bus.conv_we[i] = 1'b1;
        if (dir_hi) begin
          // high byte fills code 13:6, low part kept
          chan_bus.conv_val[i] = {reg_wdata_in,
                                  cur[dcb_pkg::LO_W-1:0]}; // see RL2
        end else begin
          // bits 1:0 of the write are dropped
          chan_bus.conv_val[i] = {cur[dcb_pkg::CODE_W-1:dcb_pkg::LO_W],
                                  reg_wdata_in[7:dcb_pkg::LO_LSB]}; // see RL1
        end
      end
      // select as held before this write; a select write is its own access
      if (reg_wr_in && wr_bc && bank_reg.sel[i]) begin
        chan_bus.conv_we[i] = 1'b1; // see RL6, RL14
      end
      if (reg_wr_in && wr_bi && bank_reg.sel[i]) begin
        chan_bus.in_we[i] = 1'b1; // see RL7, RL14
      end
      if (reg_wr_in && wr_load && reg_wdata_in[i]) begin
        chan_bus.load[i] = 1'b1; // see RL12
      end
      if (i == 0 && reg_wr_in && wr_in0) begin
        chan_bus.in_we[i] = 1'b1;
        cur = chan_bus.in_code[i];
        if (wr_in0_hi) begin
          chan_bus.in_val[i] = {reg_wdata_in,
                                cur[dcb_pkg::LO_W-1:0]}; // see RL13
        end else begin
          chan_bus.in_val[i] = {cur[dcb_pkg::CODE_W-1:dcb_pkg::LO_W],
                                reg_wdata_in[7:dcb_pkg::LO_LSB]}; // see RL13
        end
      end
    end
  end

  // read mux; write-only and unmapped offsets read as zero
  always_comb begin
    rd_byte = dcb_pkg::RESET_BYTE;
    rd_mapped = 1'b1;
    case (reg_addr_in)
      dcb_pkg::OFS_CH3_LO: rd_byte = {conv_codes_out[3][dcb_pkg::LO_W-1:0],
                                      dcb_pkg::RSVD_LO}; // see RL3
      dcb_pkg::OFS_CH3_HI:
        rd_byte = conv_codes_out[3][dcb_pkg::CODE_W-1:dcb_pkg::LO_W];
      dcb_pkg::OFS_CH4_LO: rd_byte = {conv_codes_out[4][dcb_pkg::LO_W-1:0],
                                      dcb_pkg::RSVD_LO}; // see RL3
      dcb_pkg::OFS_CH4_HI:
        rd_byte = conv_codes_out[4][dcb_pkg::CODE_W-1:dcb_pkg::LO_W];
      dcb_pkg::OFS_CH5_LO: rd_byte = {conv_codes_out[5][dcb_pkg::LO_W-1:0],
                                      dcb_pkg::RSVD_LO}; // see RL3
      dcb_pkg::OFS_CH5_HI:
        rd_byte = conv_codes_out[5][dcb_pkg::CODE_W-1:dcb_pkg::LO_W];
      dcb_pkg::OFS_BC_LO: rd_byte = {bank_reg.bc_code[dcb_pkg::LO_W-1:0],
                                     dcb_pkg::RSVD_LO}; // see RL8
      dcb_pkg::OFS_BC_HI:
        rd_byte = bank_reg.bc_code[dcb_pkg::CODE_W-1:dcb_pkg::LO_W];
      dcb_pkg::OFS_SEL:
        rd_byte = {dcb_pkg::RSVD_SEL, bank_reg.sel}; // see RL10
      dcb_pkg::OFS_BI_LO: rd_byte = {bank_reg.bi_code[dcb_pkg::LO_W-1:0],
                                     dcb_pkg::RSVD_LO}; // see RL9
      dcb_pkg::OFS_BI_HI:
        rd_byte = bank_reg.bi_code[dcb_pkg::CODE_W-1:dcb_pkg::LO_W];
      dcb_pkg::OFS_SW_LOAD: rd_byte = dcb_pkg::RESET_BYTE; // see RL11
      dcb_pkg::OFS_CH0_IN_LO:
        rd_byte = {input_codes_out[0][dcb_pkg::LO_W-1:0], dcb_pkg::RSVD_LO};
      dcb_pkg::OFS_CH0_IN_HI:
        rd_byte = input_codes_out[0][dcb_pkg::CODE_W-1:dcb_pkg::LO_W];
      default: rd_mapped = 1'b0;
    endcase
  end

  // next bank state
  always_comb begin
    bank_next = bank_reg;
    bank_next.bc_code = bc_new;
    bank_next.bi_code = bi_new;
    if (reg_wr_in && reg_addr_in == dcb_pkg::OFS_SEL) begin
      // bits 7:6 are not stored, so they always read zero
      bank_next.sel = reg_wdata_in[dcb_pkg::SEL_W-1:0]; // see RL10
    end
    // a read answers the value held before a same-cycle write
    bank_next.rvalid = reg_rd_in;
    if (reg_rd_in) begin
      bank_next.rdata = rd_byte;
    end
    // flag any access to an offset this bank does not hold
    bank_next.err = (reg_rd_in && !rd_mapped) || (reg_wr_in && !wr_mapped);
  end

  // synchronous reset to all zero
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      bank_reg.bc_code <= dcb_pkg::RESET_CODE; // see RL4
      bank_reg.bi_code <= dcb_pkg::RESET_CODE;
      bank_reg.sel <= dcb_pkg::RESET_SEL;
      bank_reg.rdata <= dcb_pkg::RESET_BYTE;
      bank_reg.rvalid <= 1'b0;
      bank_reg.err <= 1'b0;
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign reg_rdata_out = bank_reg.rdata;
  assign reg_rvalid_out = bank_reg.rvalid;
  assign reg_err_out = bank_reg.err;

endmodule : dcb_code_bank

// *** bench/dcb_code_bank_properties.sv ***
// port assertions for the converter code bank
// assumes binding onto dcb_code_bank, one clock domain
`timescale 1ns/100ps
module dcb_code_bank_properties (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic reg_err_out,
  input wire logic [5:0][13:0] conv_codes_out,
  input wire logic [5:0][13:0] input_codes_out
);
  logic [5:0] sel_reg;
  wire [7:0] a = reg_addr_in;
  wire w = reg_wr_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  // shadow of the select byte, needed to predict the copies
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sel_reg <= 6'h00;
    end else if (w && a == dcb_pkg::OFS_SEL) begin
      sel_reg <= reg_wdata_in[5:0];
    end
  end

  property p_lo_rsvd;
    reg_rd_in && a == dcb_pkg::OFS_BC_LO |=> reg_rdata_out[1:0] == 2'h0;
  endproperty
  a_lo_rsvd: assert property (p_lo_rsvd) else $error("low bits");
  // a select write in the same cycle must not show in this read
  property p_sel_rd;
    reg_rd_in && a == dcb_pkg::OFS_SEL
      |=> reg_rdata_out == {2'h0, $past(sel_reg)};
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("select read");
  property p_wo;
    reg_rd_in && a == dcb_pkg::OFS_SW_LOAD |=> reg_rdata_out == 8'h00;
  endproperty
  a_wo: assert property (p_wo) else $error("trigger read");
  // reset must clear codes even though other checks are off then
  property p_reset;
    disable iff (1'b0) !nrst_in |=> conv_codes_out == '0
      && input_codes_out == '0 && !reg_rvalid_out && !reg_err_out;
  endproperty
  a_reset: assert property (p_reset) else $error("not cleared");
  property p_hi;
    w && a == dcb_pkg::OFS_CH3_HI
      |=> conv_codes_out[3][13:6] == $past(reg_wdata_in);
  endproperty
  a_hi: assert property (p_hi) else $error("ch3 high");
  property p_lo;
    w && a == dcb_pkg::OFS_CH4_LO
      |=> conv_codes_out[4][5:0] == $past(reg_wdata_in[7:2])
      && $stable(conv_codes_out[4][13:6]);
  endproperty
  a_lo: assert property (p_lo) else $error("ch4 low");
  property p_bc;
    w && a == dcb_pkg::OFS_BC_HI && sel_reg[5]
      |=> conv_codes_out[5][13:6] == $past(reg_wdata_in);
  endproperty
  a_bc: assert property (p_bc) else $error("copy");
  property p_bi;
    w && a == dcb_pkg::OFS_BI_LO && sel_reg[4]
      |=> input_codes_out[4][5:0] == $past(reg_wdata_in[7:2]);
  endproperty
  a_bi: assert property (p_bi) else $error("input copy");
  property p_load;
    w && a == dcb_pkg::OFS_SW_LOAD && reg_wdata_in[5]
      |=> conv_codes_out[5] == $past(input_codes_out[5]);
  endproperty
  a_load: assert property (p_load) else $error("load");
endmodule : dcb_code_bank_properties

bind dcb_code_bank dcb_code_bank_properties dcb_code_bank_properties_i (
  .clk_sys_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .reg_err_out,
  .conv_codes_out, .input_codes_out);

// *** bench/dcb_host_model.sv ***
// host side: byte-wide register accesses on the bank port
// assumes strobes sampled on the rising edge of clk_sys_in
`timescale 1ns/100ps
module dcb_host_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] reg_rdata_out,
  output logic [7:0] reg_addr_in,
  output logic [7:0] reg_wdata_in,
  output logic reg_wr_in,
  output logic reg_rd_in
);
  // quiet port from time zero
  initial begin
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
  end

  // strobes stay up on return so back-to-back calls never
  // drive one twice in a time step; idle drops them
  task automatic put(input logic [7:0] ad, d, input logic wr);
    reg_addr_in = ad;
    reg_wdata_in = d;
    reg_wr_in = wr;
    reg_rd_in = !wr;
    @(posedge clk_sys_in);
    #1;
  endtask : put

  task automatic get(input logic [7:0] ad, output logic [7:0] d);
    put(ad, 8'h00, 1'b0);
    d = reg_rdata_out;
  endtask : get

  task automatic idle();
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
  endtask : idle
endmodule : dcb_host_model

// *** bench/test_dcb_code_bank.sv ***
// self-checking bench for the converter code bank
// assumes dcb_host_model drives the register port
`timescale 1ns/100ps
module test_dcb_code_bank;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rb;
  logic reg_wr_in, reg_rd_in, reg_rvalid_out, reg_err_out;
  logic [5:0][13:0] conv_codes_out, input_codes_out;
  int miscompares = 0;
  int num_checks = 0;

  // 10 MHz system clock
  always #50 clk_sys_in = !clk_sys_in;

  dcb_code_bank dcb_code_bank_i (.clk_sys_in, .nrst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .reg_rvalid_out, .reg_err_out, .conv_codes_out, .input_codes_out);
  dcb_host_model dcb_host_model_i (.clk_sys_in, .reg_rdata_out,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in);

  task automatic chk(input logic [13:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] ad, d);
    dcb_host_model_i.put(ad, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] ad, exp);
    dcb_host_model_i.get(ad, rb);
    chk({6'h00, rb}, {6'h00, exp});
    // answer stands one cycle, mapped offsets raise no error
    chk_bit(reg_rvalid_out, 1'b1);
    chk_bit(reg_err_out, 1'b0);
  endtask : rd

  task automatic t_reset();
    for (int i = 8'h2c; i <= 8'h39; i++) begin
      rd(8'(i), 8'h00);
    end
    for (int g = 0; g < 6; g++) begin
      chk(input_codes_out[g], 14'h0000);
      chk(conv_codes_out[g], 14'h0000);
    end
  endtask : t_reset

  // reset in mid-run clears everything written so far
  task automatic t_midreset();
    dcb_host_model_i.idle();
    nrst_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    t_reset();
  endtask : t_midreset

  // offsets outside the bank: ignored, flagged, read as zero
  task automatic t_unmapped();
    dcb_host_model_i.get(8'h2b, rb);
    chk({6'h00, rb}, 14'h0000);
    chk_bit(reg_err_out, 1'b1);
    wr(8'h3a, 8'hff);
    chk_bit(reg_err_out, 1'b1);
    chk_bit(reg_rvalid_out, 1'b0);
    chk(input_codes_out[1], 14'h0000);
    wr(dcb_pkg::OFS_SEL, 8'h00);
    chk_bit(reg_err_out, 1'b0);
  endtask : t_unmapped

  // back-to-back direct writes, halves kept apart
  task automatic t_direct();
    wr(dcb_pkg::OFS_CH3_LO, 8'h9b);
    wr(dcb_pkg::OFS_CH3_HI, 8'ha5);
    wr(dcb_pkg::OFS_CH4_LO, 8'hff);
    wr(dcb_pkg::OFS_CH4_HI, 8'h3c);
    wr(dcb_pkg::OFS_CH5_LO, 8'h57);
    chk(conv_codes_out[3], {8'ha5, 6'h26});
    rd(dcb_pkg::OFS_CH3_LO, 8'h98);
    chk(conv_codes_out[4], {8'h3c, 6'h3f});
    chk(conv_codes_out[5], {8'h00, 6'h15});
    rd(dcb_pkg::OFS_CH4_LO, 8'hfc);
  endtask : t_direct

  task automatic t_bcast();
    wr(dcb_pkg::OFS_SEL, 8'hff);
    rd(dcb_pkg::OFS_SEL, 8'h3f);
    wr(dcb_pkg::OFS_SEL, 8'h29);
    wr(dcb_pkg::OFS_BC_LO, 8'h8f);
    chk(conv_codes_out[0], {8'h00, 6'h23});
    wr(dcb_pkg::OFS_BC_HI, 8'h71);
    chk(conv_codes_out[5], {8'h71, 6'h23});
    chk(conv_codes_out[4], {8'h3c, 6'h3f});
    chk(conv_codes_out[1], 14'h0000);
    rd(dcb_pkg::OFS_CH3_HI, 8'h71);
    rd(dcb_pkg::OFS_BC_LO, 8'h8c);
  endtask : t_bcast

  task automatic t_input_load();
    wr(dcb_pkg::OFS_SEL, 8'h31);
    wr(dcb_pkg::OFS_BI_LO, 8'h44);
    wr(dcb_pkg::OFS_BI_HI, 8'hc3);
    chk(input_codes_out[5], {8'hc3, 6'h11});
    chk(input_codes_out[3], 14'h0000);
    chk(conv_codes_out[5], {8'h71, 6'h23});
    rd(dcb_pkg::OFS_CH0_IN_LO, 8'h44);
    rd(dcb_pkg::OFS_CH0_IN_HI, 8'hc3);
    wr(dcb_pkg::OFS_SW_LOAD, 8'h20);
    chk(conv_codes_out[5], {8'hc3, 6'h11});
    chk(conv_codes_out[4], {8'h3c, 6'h3f});
    rd(dcb_pkg::OFS_SW_LOAD, 8'h00);
    wr(dcb_pkg::OFS_BI_HI, 8'h0f);
    wr(dcb_pkg::OFS_SW_LOAD, 8'h00);
    chk(conv_codes_out[5], {8'hc3, 6'h11});
    wr(dcb_pkg::OFS_CH0_IN_LO, 8'hab);
    rd(dcb_pkg::OFS_CH0_IN_LO, 8'ha8);
    wr(dcb_pkg::OFS_CH0_IN_HI, 8'h5a);
    chk(input_codes_out[0], {8'h5a, 6'h2a});
    wr(dcb_pkg::OFS_SW_LOAD, 8'h11);
    chk(conv_codes_out[0], {8'h5a, 6'h2a});
    chk(conv_codes_out[4], {8'h0f, 6'h11});
  endtask : t_input_load

  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // hold reset 8 cycles, then run the scenarios
  initial begin
    repeat (8) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    t_reset();
    t_direct();
    t_unmapped();
    t_bcast();
    t_input_load();
    t_midreset();
    dcb_host_model_i.idle();
    results();
  end

  // the run needs some 72 cycles; cut a hang short
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule : test_dcb_code_bank
